// >>> design/jtp_pkg.sv
// jtp_pkg: constants, state codes and carrier types of the test access port.
// assumes: included before jtp_tap; all logic runs on hclk.
`default_nettype none
package jtp_pkg;

  //////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int NUM_IO  = 4;
  localparam int BSR_LEN = NUM_IO * 3;
  localparam int IR_LEN  = 5;
  localparam int ID_LEN  = 20;
  localparam int USR_LEN = 33;
  localparam int DR_MAX  = 33;

  // arbitrary neutral identity value
  localparam logic [ID_LEN-1:0] ID_CODE_DEFAULT = 20'h5A5A3;

  //////////////////////////////////////////////////////////////////////////
  // instruction codes
  localparam logic [IR_LEN-1:0] INSTR_EXTEST = 5'h00;
  localparam logic [IR_LEN-1:0] INSTR_SAMPLE = 5'h01;
  localparam logic [IR_LEN-1:0] INSTR_USR    = 5'h0E;
  localparam logic [IR_LEN-1:0] INSTR_ID     = 5'h0F;
  localparam logic [IR_LEN-1:0] INSTR_BYPASS = 5'h1F;
  // shifts out lsb first as 1,0,1,1,1
  localparam logic [IR_LEN-1:0] IR_CAP_FIXED = 5'h1D;

  //////////////////////////////////////////////////////////////////////////
  // register offsets and fields
  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_INT_STAT = 8'h04;
  localparam logic [7:0] OFS_INT_MASK = 8'h08;
  localparam logic [7:0] OFS_USR_LO   = 8'h0C;
  localparam logic [7:0] OFS_USR_HI   = 8'h10;
  localparam int STAT_IR_POS  = 16;
  localparam int STAT_ERR_POS = 21;
  localparam int EV_W     = 3;
  localparam int EV_TLR   = 0;
  localparam int EV_UP_IR = 1;
  localparam int EV_UP_DR = 2;
  localparam logic [EV_W-1:0] INT_RST = 3'h0;

  //////////////////////////////////////////////////////////////////////////
  // synchroniser vector layout
  localparam int SY_TCK   = 0;
  localparam int SY_TMS   = 1;
  localparam int SY_TDI   = 2;
  localparam int SY_TRST  = 3;
  localparam int SY_ERR   = 4;
  localparam int SY_PWR   = 7;
  localparam int SY_START = 8;
  localparam int SY_PROBE = 9;
  localparam int SY_PAD   = 10;
  localparam int SYNC_W   = SY_PAD + NUM_IO;

  //////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [15:0] {
    ST_TLR    = 16'h0001, ST_RTI    = 16'h0002,
    ST_SEL_DR = 16'h0004, ST_CAP_DR = 16'h0008,
    ST_SH_DR  = 16'h0010, ST_EX1_DR = 16'h0020,
    ST_PA_DR  = 16'h0040, ST_EX2_DR = 16'h0080,
    ST_UP_DR  = 16'h0100, ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400, ST_SH_IR  = 16'h0800,
    ST_EX1_IR = 16'h1000, ST_PA_IR  = 16'h2000,
    ST_EX2_IR = 16'h4000, ST_UP_IR  = 16'h8000
  } jtp_state_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } jtp_aphase_t;

endpackage
`default_nettype wire

// >>> design/jtp_tap.sv
// jtp_tap: boundary-scan test access port with an AHB-Lite status port.
// assumes: tck, tms, tdi, trst_n and all pad inputs are asynchronous to
// hclk, and tck is far slower than hclk (at least 8 hclk per tck phase).
//
// The implementer's own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module jtp_tap
  import jtp_pkg::*;
#(
  parameter logic [ID_LEN-1:0] ID_CODE = ID_CODE_DEFAULT
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output var  logic [31:0]       hrdata,
  output var  logic              hreadyout,
  output var  logic              hresp,
  output var  logic              irq,
  input  wire logic              tck,
  input  wire logic              tms,
  input  wire logic              tdi,
  input  wire logic              trst_n,
  output var  logic              tdo,
  output var  logic              tdo_oe,
  input  wire logic              output_error_n,
  input  wire logic              probe_one_error_n,
  input  wire logic              probe_two_error_n,
  input  wire logic              power_up_done,
  input  wire logic              startup_mode,
  input  wire logic              probe_used,
  input  wire logic [NUM_IO-1:0] core_out,
  input  wire logic [NUM_IO-1:0] core_oe,
  output var  logic [NUM_IO-1:0] core_in,
  input  wire logic [NUM_IO-1:0] pad_in,
  output var  logic [NUM_IO-1:0] pad_out,
  output var  logic [NUM_IO-1:0] pad_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers and tck edges
  logic [SYNC_W-1:0]  sy_raw;
  logic [SYNC_W-1:0]  sy1;
  logic [SYNC_W-1:0]  sy2;
  logic               tck_d;
  logic               tck_rise;
  logic               tck_fall;
  logic               tms_s;
  logic               tdi_s;
  logic               trst_s;
  logic [NUM_IO-1:0]  pad_s;

  assign sy_raw = {pad_in, probe_used, startup_mode, power_up_done,
                   probe_two_error_n, probe_one_error_n, output_error_n,
                   trst_n, tdi, tms, tck};

  // errors reset inactive and tck low, as the pins idle, so no false
  // error or tck edge follows reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sy1   <= {{(SYNC_W-1){1'b1}}, 1'b0};
      sy2   <= {{(SYNC_W-1){1'b1}}, 1'b0};
      tck_d <= 1'b0;
    end else begin
      sy1   <= sy_raw;
      sy2   <= sy1;
      tck_d <= sy2[SY_TCK];
    end
  end

  assign tck_rise = sy2[SY_TCK] & ~tck_d;
  assign tck_fall = ~sy2[SY_TCK] & tck_d;
  assign tms_s    = sy2[SY_TMS];
  assign tdi_s    = sy2[SY_TDI];
  assign trst_s   = sy2[SY_TRST];
  assign pad_s    = sy2[SY_PAD +: NUM_IO];

  ////////////////////////////////////////////////////////////////////////////
  // tap state machine
  jtp_state_t state;
  jtp_state_t next_state;
  logic       in_tlr;
  logic       in_tlr_d;
  logic       up_ir;
  logic       up_dr;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_TLR:    next_state = tms_s ? ST_TLR    : ST_RTI;
      ST_RTI:    next_state = tms_s ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: next_state = tms_s ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: next_state = tms_s ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  next_state = tms_s ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: next_state = tms_s ? ST_UP_DR  : ST_PA_DR;
      ST_PA_DR:  next_state = tms_s ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: next_state = tms_s ? ST_UP_DR  : ST_SH_DR;
      ST_UP_DR:  next_state = tms_s ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: next_state = tms_s ? ST_TLR    : ST_CAP_IR;
      ST_CAP_IR: next_state = tms_s ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  next_state = tms_s ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: next_state = tms_s ? ST_UP_IR  : ST_PA_IR;
      ST_PA_IR:  next_state = tms_s ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: next_state = tms_s ? ST_UP_IR  : ST_SH_IR;
      ST_UP_IR:  next_state = tms_s ? ST_SEL_DR : ST_RTI;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state    <= ST_TLR;
      in_tlr_d <= 1'b1;
    end else begin
      in_tlr_d <= in_tlr;
      if (!trst_s) begin
        state <= ST_TLR;
      end else if (tck_rise) begin
        state <= next_state;
      end
    end
  end

  assign in_tlr = (state == ST_TLR);
  assign up_ir  = tck_rise && (state == ST_UP_IR);
  assign up_dr  = tck_rise && (state == ST_UP_DR);

  ////////////////////////////////////////////////////////////////////////////
  // error flags and instruction register
  logic [2:0]        err_pend;
  logic [2:0]        err_set;
  logic              p1_flag;
  logic [IR_LEN-1:0] ir;
  logic [IR_LEN-1:0] ir_shift;
  logic [IR_LEN-1:0] ir_cap;

  assign err_set = ~sy2[SY_ERR +: 3];

  // a new error in the clearing cycle stays pending
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_pend <= 3'h0;
    end else if (in_tlr || up_ir) begin
      err_pend <= err_set;
    end else begin
      err_pend <= err_pend | err_set;
    end
  end

  // unprobed start-up reuses probe one bit as power-up done
  assign p1_flag = (sy2[SY_START] && !sy2[SY_PROBE]) ? sy2[SY_PWR]
                                                    : ~err_pend[1];
  assign ir_cap  = {IR_CAP_FIXED[4] & ~err_pend[2],
                    IR_CAP_FIXED[3] & p1_flag,
                    IR_CAP_FIXED[2] & ~err_pend[0],
                    IR_CAP_FIXED[1:0]};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ir_shift <= IR_CAP_FIXED;
    end else if (tck_rise && state == ST_CAP_IR) begin
      ir_shift <= ir_cap;
    end else if (tck_rise && state == ST_SH_IR) begin
      ir_shift <= {tdi_s, ir_shift[IR_LEN-1:1]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ir <= INSTR_ID;
    end else if (in_tlr) begin
      ir <= INSTR_ID;
    end else if (up_ir) begin
      ir <= ir_shift;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data registers
  logic [DR_MAX-1:0]  dr_shift;
  logic [DR_MAX-1:0]  dr_cap;
  logic [DR_MAX-1:0]  dr_shifted;
  logic [5:0]         dr_len;
  logic [USR_LEN-1:0] user_signature;
  logic [BSR_LEN-1:0] bsr_cap;
  logic [BSR_LEN-1:0] bsr_latch;
  logic               sel_bsr;
  logic               extest;

  assign sel_bsr = (ir == INSTR_EXTEST) || (ir == INSTR_SAMPLE);
  assign extest  = (ir == INSTR_EXTEST);

  // per io: enable nearest the serial output, then output, then input
  for (genvar i = 0; i < NUM_IO; i++) begin : g_cell
    assign bsr_cap[3*i]   = core_oe[i];
    assign bsr_cap[3*i+1] = core_out[i];
    assign bsr_cap[3*i+2] = pad_s[i];
  end

  always_comb begin
    unique case (ir)
      INSTR_ID: begin
        dr_len = 6'(ID_LEN);
        dr_cap = DR_MAX'(ID_CODE);
      end
      INSTR_USR: begin
        dr_len = 6'(USR_LEN);
        dr_cap = user_signature;
      end
      INSTR_EXTEST, INSTR_SAMPLE: begin
        dr_len = 6'(BSR_LEN);
        dr_cap = DR_MAX'(bsr_cap);
      end
      default: begin
        dr_len = 6'h01;
        dr_cap = '0;
      end
    endcase
  end

  always_comb begin
    dr_shifted = '0;
    for (int k = 0; k < DR_MAX - 1; k++) begin
      if (6'(k) == dr_len - 6'h01) begin
        dr_shifted[k] = tdi_s;
      end else if (6'(k) < dr_len - 6'h01) begin
        dr_shifted[k] = dr_shift[k+1];
      end
    end
    if (dr_len == 6'(DR_MAX)) begin
      dr_shifted[DR_MAX-1] = tdi_s;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dr_shift <= '0;
    end else if (tck_rise && state == ST_CAP_DR) begin
      dr_shift <= dr_cap;
    end else if (tck_rise && state == ST_SH_DR) begin
      dr_shift <= dr_shifted;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bsr_latch <= '0;
    end else if (up_dr && sel_bsr) begin
      bsr_latch <= dr_shift[BSR_LEN-1:0];
    end
  end

  // pad drive muxes: latch in external test, core otherwise
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_out <= '0;
      pad_oe  <= '0;
      core_in <= '0;
    end else begin
      core_in <= pad_s;
      for (int i = 0; i < NUM_IO; i++) begin
        pad_oe[i]  <= extest ? bsr_latch[3*i]   : core_oe[i];
        pad_out[i] <= extest ? bsr_latch[3*i+1] : core_out[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial output, retimed to the falling tck edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (!trst_s) begin
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe <= (state == ST_SH_IR) || (state == ST_SH_DR);
      tdo    <= (state == ST_SH_IR) ? ir_shift[0] : dr_shift[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave; reads take one wait state so that a write just ahead
  // is always visible to them
  jtp_aphase_t ap;
  logic              accept;
  logic              rd_wait;
  logic [EV_W-1:0]   int_stat;
  logic [EV_W-1:0]   int_mask;
  logic [EV_W-1:0]   ev;
  logic              wr_en;

  assign accept    = hsel && htrans[1] && hready;
  assign hreadyout = ~rd_wait;
  assign hresp     = 1'b0;
  assign wr_en     = ap.valid && ap.write && !rd_wait;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap      <= '0;
      rd_wait <= 1'b0;
    end else begin
      if (hready) begin
        ap <= '{valid: accept, write: hwrite, addr: haddr[7:0]};
      end
      rd_wait <= accept && !hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (rd_wait) begin
      unique case (ap.addr)
        OFS_STATUS:   hrdata <= {8'h00, err_pend, ir, state};
        OFS_INT_STAT: hrdata <= 32'(int_stat);
        OFS_INT_MASK: hrdata <= 32'(int_mask);
        OFS_USR_LO:   hrdata <= user_signature[31:0];
        OFS_USR_HI:   hrdata <= 32'(user_signature[USR_LEN-1:32]);
        default:      hrdata <= '0;
      endcase
    end
  end

  // programming only sets ones; unprogrammed bits stay zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      user_signature <= '0;
    end else if (wr_en && ap.addr == OFS_USR_LO) begin
      user_signature[31:0] <= user_signature[31:0] | hwdata;
    end else if (wr_en && ap.addr == OFS_USR_HI) begin
      user_signature[32] <= user_signature[32] | hwdata[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts
  always_comb begin
    ev           = '0;
    ev[EV_TLR]   = in_tlr && !in_tlr_d;
    ev[EV_UP_IR] = up_ir;
    ev[EV_UP_DR] = up_dr;
  end

  // an event in the clearing cycle wins over the write of one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_stat <= INT_RST;
      int_mask <= INT_RST;
    end else begin
      if (wr_en && ap.addr == OFS_INT_STAT) begin
        int_stat <= (int_stat & ~hwdata[EV_W-1:0]) | ev;
      end else begin
        int_stat <= int_stat | ev;
      end
      if (wr_en && ap.addr == OFS_INT_MASK) begin
        int_mask <= hwdata[EV_W-1:0];
      end
    end
  end

  assign irq = |(int_stat & int_mask);

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_TDO_HIZ: assert property (
    tck_fall && trst_s && state != ST_SH_IR && state != ST_SH_DR
    |=> !tdo_oe) else $error("serial output enabled outside shift");

  AST_TDO_LSB: assert property (
    tck_fall && trst_s && state == ST_SH_IR
    |=> tdo == $past(ir_shift[0]) && tdo_oe)
    else $error("serial output not ir lsb");

  AST_TLR_STEP: assert property (
    trst_s && tck_rise && state == ST_SEL_IR && tms_s
    |=> state == ST_TLR ##1 state == ST_TLR)
    else $error("select-ir with mode high did not reach reset");

  AST_IR_RESET: assert property (
    trst_s && state == ST_TLR |=> ir == INSTR_ID)
    else $error("identity instruction not loaded in reset state");

  AST_IR_CAPTURE: assert property (
    tck_rise && state == ST_CAP_IR && err_pend == 3'h0
    && !(sy2[SY_START] && !sy2[SY_PROBE])
    |=> ir_shift == IR_CAP_FIXED)
    else $error("clean capture is not the fixed pattern");

  AST_IR_ERR: assert property (
    tck_rise && state == ST_CAP_IR && err_pend[2]
    |=> ir_shift[4] == 1'b0 && ir_shift[1:0] == 2'b01)
    else $error("probe two error not shown");

  AST_ERR_CLR: assert property (
    up_ir && err_set == 3'h0 |=> err_pend == 3'h0)
    else $error("errors not cleared at update-ir");

  AST_ID_CAP: assert property (
    tck_rise && state == ST_CAP_DR && ir == INSTR_ID
    |=> dr_shift[ID_LEN-1:0] == ID_CODE)
    else $error("identity not captured");

  AST_DR_MSB: assert property (
    tck_rise && state == ST_SH_DR && ir == INSTR_ID
    |=> dr_shift[ID_LEN-1] == $past(tdi_s)
    && dr_shift[0] == $past(dr_shift[1]))
    else $error("data register not shifting msb-in lsb-out");

  AST_BYPASS: assert property (
    tck_rise && state == ST_CAP_DR && !sel_bsr
    && ir != INSTR_ID && ir != INSTR_USR
    |=> dr_shift == '0) else $error("passthrough capture not zero");

  AST_USR_ZERO: assert property (
    tck_rise && state == ST_CAP_DR && ir == INSTR_USR
    && user_signature == '0 |=> dr_shift == '0)
    else $error("unprogrammed signature not zero");

  COV_UP_IR: cover property (up_ir);
  COV_USR_SHIFT: cover property (tck_rise && state == ST_SH_DR
                                 && ir == INSTR_USR);
  COV_ERR: cover property (tck_rise && state == ST_CAP_IR && |err_pend);
  COV_IRQ: cover property (!irq ##1 irq);

endmodule
`default_nettype wire

// >>> test/jtp_host_model.sv
// jtp_host_model: behavioural test controller on the far side of the link.
// assumes: the bench calls one task at a time; tck rests low between frames.
`timescale 1ns/1ps
`default_nettype none
module jtp_host_model (
  output var  logic tck,
  output var  logic tms,
  output var  logic tdi,
  output var  logic trst_n,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  logic last;
  logic line;

  // a released line shows the inverse of the last bit, so a stale copy cannot pass
  always @(tdo or tdo_oe) if (tdo_oe) last = tdo;
  assign line = tdo_oe ? tdo : ~last;

  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // one tck period of 125 ns; tdo is taken just before the rising edge
  task automatic step(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    #62.5;
    q = line;
    tck <= 1'b1;
    #62.5;
    tck <= 1'b0;
  endtask

  task automatic walk(input logic [7:0] seq, input int n);
    logic q;
    for (int i = 0; i < n; i++) step(seq[i], 1'b0, q);
  endtask

  // from idle through one scan and back to idle
  task automatic scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
    dout = '0;
    if (ir) walk(8'h03, 4);
    else walk(8'h01, 3);
    for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
    walk(8'h01, 2);
  endtask

  task automatic idle_reset(input logic hard);
    if (hard) begin
      trst_n <= 1'b0;
      #500;
      trst_n <= 1'b1;
      #500;
    end else walk(8'h1F, 5);
    walk(8'h00, 1);
  endtask
endmodule
`default_nettype wire

// >>> test/jtp_tap_tb.sv
// jtp_tap_tb: self-checking bench for the test access port.
// assumes: jtp_host_model plays the test controller; the tap is the one AHB slave.
`timescale 1ns/1ps
`default_nettype none
module jtp_tap_tb;
  import jtp_pkg::*;
  logic              hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic              tck, tms, tdi, trst_n, tdo, tdo_oe;
  logic              output_error_n, probe_one_error_n, probe_two_error_n;
  logic              power_up_done, startup_mode, probe_used;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic [31:0]       haddr, hwdata, hrdata, rd;
  logic [NUM_IO-1:0] core_out, core_oe, core_in, pad_in, pad_out, pad_oe;
  logic [63:0]       q, e;
  int                err_count, comparisons;

  jtp_tap jtp_tap_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .output_error_n(output_error_n),
    .probe_one_error_n(probe_one_error_n), .probe_two_error_n(probe_two_error_n),
    .power_up_done(power_up_done), .startup_mode(startup_mode), .probe_used(probe_used),
    .core_out(core_out), .core_oe(core_oe), .core_in(core_in), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe));
  jtp_host_model jtp_host_model_i (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
    .tdo(tdo), .tdo_oe(tdo_oe));

  always #2 hclk = ~hclk;

  ////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("comparisons %0d, err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // single word transfer; both phases wait for hready under a bound
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 20) begin
      @(posedge hclk);
      n++;
    end
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 20) begin
      @(posedge hclk);
      n++;
    end
    rd = hrdata;
    if (n >= 20) begin
      err_count++;
      finish_test();
    end
  endtask

  // sources settle through the synchronisers well within ten cycles
  task automatic pins(input logic [2:0] err_n, input logic [2:0] su);
    @(posedge hclk);
    {probe_two_error_n, probe_one_error_n, output_error_n} <= err_n;
    {startup_mode, probe_used, power_up_done} <= su;
    repeat (10) @(posedge hclk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_idcode();
    jtp_host_model_i.scan(1'b0, ID_LEN, 64'h0, q);
    chk("idcode", ID_CODE_DEFAULT, q);
    chk("tdo_oe idle", 1'b0, tdo_oe);
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk("status", {INSTR_ID, 16'h0002}, rd[20:0]);
    chk("hresp", 1'b0, hresp);
  endtask

  task automatic t_ircap();
    for (int k = 0; k < 3; k++) begin
      pins(3'h7 ^ (3'h1 << k), 3'h0);
      pins(3'h7, 3'h0);
      jtp_host_model_i.scan(1'b1, IR_LEN, INSTR_BYPASS, q);
      chk("ir capture err", IR_CAP_FIXED & ~(5'h04 << k), q);
      jtp_host_model_i.scan(1'b1, IR_LEN, INSTR_ID, q);
      chk("ir capture clean", IR_CAP_FIXED, q);
    end
  endtask

  task automatic t_powerup();
    logic [2:0] su [3];
    logic [4:0] ex [3];
    su = '{3'h4, 3'h5, 3'h6};
    ex = '{5'h15, 5'h1D, 5'h1D};
    for (int k = 0; k < 3; k++) begin
      pins(3'h7, su[k]);
      jtp_host_model_i.scan(1'b1, IR_LEN, INSTR_ID, q);
      chk("power-up flag", ex[k], q);
    end
    pins(3'h7, 3'h0);
  endtask

  task automatic t_bypass();
    logic [4:0] c [3];
    c = '{5'h05, INSTR_BYPASS, 5'h13};
    for (int k = 0; k < 3; k++) begin
      jtp_host_model_i.scan(1'b1, IR_LEN, c[k], q);
      jtp_host_model_i.scan(1'b0, 8, 64'hA5, q);
      chk("bypass", 64'h4A, q);
    end
  endtask

  task automatic t_user();
    jtp_host_model_i.scan(1'b1, IR_LEN, INSTR_USR, q);
    jtp_host_model_i.scan(1'b0, USR_LEN, 64'h0, q);
    chk("blank signature", 64'h0, q);
    ahb(1'b1, OFS_USR_LO, 32'h80000001);
    ahb(1'b1, OFS_USR_HI, 32'h00000001);
    ahb(1'b1, OFS_USR_LO, 32'h00000100);
    ahb(1'b1, OFS_USR_HI, 32'h00000000);
    jtp_host_model_i.scan(1'b1, IR_LEN, INSTR_USR, q);
    jtp_host_model_i.scan(1'b0, USR_LEN, 64'h0, q);
    chk("user signature", 64'h180000101, q);
    jtp_host_model_i.idle_reset(1'b0);
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk("status after soft reset", {INSTR_ID, 16'h0002}, rd[20:0]);
  endtask

  task automatic t_chain();
    logic [11:0] pat;
    pat = 12'hA5C;
    @(posedge hclk);
    core_oe <= 4'h5;
    core_out <= 4'h3;
    pad_in <= 4'h9;
    repeat (10) @(posedge hclk);
    e = '0;
    for (int i = 0; i < NUM_IO; i++) e[3*i +: 3] = {pad_in[i], core_out[i], core_oe[i]};
    jtp_host_model_i.scan(1'b1, IR_LEN, INSTR_SAMPLE, q);
    jtp_host_model_i.scan(1'b0, BSR_LEN, 64'h0, q);
    chk("sample chain", e, q);
    jtp_host_model_i.scan(1'b1, IR_LEN, INSTR_EXTEST, q);
    jtp_host_model_i.scan(1'b0, BSR_LEN, 64'hA5C, q);
    chk("extest capture", e, q);
    repeat (10) @(posedge hclk);
    chk("core_in", pad_in, core_in);
    for (int i = 0; i < NUM_IO; i++) e[2*i +: 2] = {pat[3*i+1], pat[3*i]};
    chk("pads", e[7:0], {pad_out[3], pad_oe[3], pad_out[2], pad_oe[2], pad_out[1], pad_oe[1],
      pad_out[0], pad_oe[0]});
  endtask

  task automatic t_irq();
    ahb(1'b1, OFS_INT_MASK, 32'h4);
    ahb(1'b1, OFS_INT_STAT, 32'h7);
    jtp_host_model_i.scan(1'b1, IR_LEN, INSTR_ID, q);
    ahb(1'b0, OFS_INT_STAT, 32'h0);
    chk("stat update-ir", 32'h2, rd);
    chk("irq masked", 1'b0, irq);
    jtp_host_model_i.scan(1'b0, ID_LEN, 64'h0, q);
    ahb(1'b0, OFS_INT_STAT, 32'h0);
    chk("stat update-dr", 32'h6, rd);
    chk("irq set", 1'b1, irq);
    ahb(1'b1, OFS_INT_STAT, 32'h4);
    @(posedge hclk);
    chk("irq cleared", 1'b0, irq);
    ahb(1'b1, 8'h20, 32'hFFFFFFFF);
    ahb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, rd);
    jtp_host_model_i.scan(1'b1, IR_LEN, INSTR_BYPASS, q);
    jtp_host_model_i.idle_reset(1'b1);
    ahb(1'b0, OFS_INT_STAT, 32'h0);
    chk("stat reset entry", 32'h3, rd);
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk("status after trst", {INSTR_ID, 16'h0002}, rd[20:0]);
    chk("core pads", {core_out, core_oe}, {pad_out, pad_oe});
    jtp_host_model_i.scan(1'b0, ID_LEN, 64'h0, q);
    chk("idcode after trst", ID_CODE_DEFAULT, q);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    {output_error_n, probe_one_error_n, probe_two_error_n} = 3'h7;
    {power_up_done, startup_mode, probe_used} = 3'h0;
    {core_out, core_oe, pad_in} = '0;
    err_count = 0;
    comparisons = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    jtp_host_model_i.idle_reset(1'b0);
    t_idcode();
    t_ircap();
    t_powerup();
    t_bypass();
    t_user();
    t_chain();
    t_irq();
    finish_test();
  end
endmodule
`default_nettype wire
